// ### srr_pkg.sv
package srr_pkg;
   // ---------------------------------------------------------------
   // Operation codes and bit positions
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SRR_OP_NONE = 2'h0,
      SRR_OP_SHIFT = 2'h1,
      SRR_OP_RETI = 2'h2,
      SRR_OP_RETS = 2'h3
   } srr_op_t;
   localparam int GLOBAL_EN_BIT = 7; // Enable bit inside interrupt_control_reg
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [14:0] PC_RST = 15'h0000;
   localparam int RET_CYCLES = 2;
   localparam int SHIFT_CYCLES = 1;
   // Execution sequencer states
   typedef enum logic [1:0] {
      SRR_ST_IDLE = 2'b00,
      SRR_ST_POP = 2'b01,
      SRR_ST_LOAD = 2'b10
   } srr_state_t;
endpackage : srr_pkg

// ### srr_shifter.sv
// ---------------------------------------------------------------
// Logical right shift datapath, purely combinational
// ---------------------------------------------------------------
module srr_shifter #(
   parameter int WIDTH = 8
) (
   // Operand
   input wire logic [WIDTH-1:0] operand,
   // Results
   output logic [WIDTH-1:0] result,
   output logic carryOut,
   output logic zeroOut
);
   // A one-bit operand has nothing to shift, so refuse it at elaboration
   if (WIDTH < 2)
   begin : gBadWidth
      $error("srr_shifter: width below 2");
   end

   // Zero enters the top, bit 0 leaves into carry
   assign result = {1'b0, operand[WIDTH-1:1]};
   assign carryOut = operand[0];
   assign zeroOut = (result == '0);
endmodule : srr_shifter

// ### srr_core.sv
// Contract
// - Shift sends bits 7:1 to result 6:0, zero to bit 7, bit 0 to carry.
// - Destination 0 writes the accumulator, 1 writes the operand register.
// - The shift inserts zero at the top, never sign or carry.
// - Interrupt return pops the stack into the PC and keeps status flags.
// - Interrupt return sets the global enable, bit 7 of interrupt control.
// - Interrupt return is one word and takes two cycles.
// - Subroutine return pops the stack into the PC, flags and enable kept.
// - Subroutine return takes two cycles so the pipeline refetches.
module srr_core #(
   parameter int WIDTH = 8,
   parameter int PCW = 15
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Decoded instruction
   input wire logic opValid,
   input wire srr_pkg::srr_op_t opCode,
   input wire logic destSel,
   input wire logic [WIDTH-1:0] operandIn,
   input wire logic [PCW-1:0] topOfStackEntry,
   // Datapath writes
   output logic accWe_r,
   output logic fileWe_r,
   output logic [WIDTH-1:0] resultOut_r,
   output logic carryWe_r,
   output logic carryFlag_r,
   output logic zeroWe_r,
   output logic zeroFlag_r,
   // Stack and control
   output logic stackPop_r,
   output logic pcLoad_r,
   output logic [PCW-1:0] pcOut_r,
   output logic [7:0] interruptControlReg_r,
   output logic busy_r
);
   // Refuse sizes the shifter and the return path cannot serve
   if (WIDTH < 2 || PCW < 1)
   begin : gBadParam
      $error("srr_core: unsupported width");
   end

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] shResult;
   logic shCarry;
   logic shZero;
   srr_pkg::srr_state_t state_r;
   srr_pkg::srr_state_t state_nxt;
   logic retiPend_r;
   wire idle = (state_r == srr_pkg::SRR_ST_IDLE);
   wire doShift = opValid && idle && (opCode == srr_pkg::SRR_OP_SHIFT);
   wire isReti = opCode == srr_pkg::SRR_OP_RETI;
   wire isRets = opCode == srr_pkg::SRR_OP_RETS;
   wire doRet = opValid && idle && (isReti || isRets);
   wire toFile = destSel == srr_pkg::DEST_FILE;
   wire finishRet = (state_r == srr_pkg::SRR_ST_POP);

   srr_shifter #(.WIDTH(WIDTH)) uShift (
      .operand(operandIn),
      .result(shResult),
      .carryOut(shCarry),
      .zeroOut(shZero)
   );

   // ---------------------------------------------------------------
   // Sequencer: returns hold the core for a second cycle
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         srr_pkg::SRR_ST_IDLE:
         begin
            if (doRet)
               state_nxt = srr_pkg::SRR_ST_POP;
         end
         srr_pkg::SRR_ST_POP: state_nxt = srr_pkg::SRR_ST_IDLE;
         default: state_nxt = srr_pkg::SRR_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= srr_pkg::SRR_ST_IDLE;
         retiPend_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         retiPend_r <= doRet && isReti;
      end
   end

   // ---------------------------------------------------------------
   // Shift write-back, one cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         accWe_r <= 1'b0;
         fileWe_r <= 1'b0;
         resultOut_r <= '0;
         carryWe_r <= 1'b0;
         carryFlag_r <= 1'b0;
         zeroWe_r <= 1'b0;
         zeroFlag_r <= 1'b0;
      end
      else
      begin
         accWe_r <= doShift && !toFile;
         fileWe_r <= doShift && toFile;
         carryWe_r <= doShift; // Returns leave flags alone
         zeroWe_r <= doShift;
         if (doShift)
         begin
            resultOut_r <= shResult;
            carryFlag_r <= shCarry;
            zeroFlag_r <= shZero;
         end
      end
   end

   // ---------------------------------------------------------------
   // Return path: pop in first cycle, PC load in second
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stackPop_r <= 1'b0;
         pcLoad_r <= 1'b0;
         pcOut_r <= PCW'(srr_pkg::PC_RST);
         interruptControlReg_r <= srr_pkg::INTCTL_RST;
         busy_r <= 1'b0;
      end
      else
      begin
         stackPop_r <= doRet;
         pcLoad_r <= finishRet;
         busy_r <= doRet;
         if (doRet)
            pcOut_r <= topOfStackEntry;
         // Set only; clearing on interrupt entry belongs elsewhere
         if (finishRet && retiPend_r)
            interruptControlReg_r[srr_pkg::GLOBAL_EN_BIT] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // One clock domain, so all checks share one clock and one reset
   default clocking cbChk @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // Shift datapath: result, carry, zero flag and destination
   a_shift_result: assert property (doShift |=>
      resultOut_r == {1'b0, $past(operandIn[WIDTH-1:1])}
         && resultOut_r[WIDTH-1] == 1'b0)
      else $error("shift result wrong");
   a_shift_msb_zero: assert property ((accWe_r || fileWe_r) |->
      !resultOut_r[WIDTH-1])
      else $error("shift msb not zero");
   a_shift_carry: assert property (doShift |=>
      carryWe_r && carryFlag_r == $past(operandIn[0]))
      else $error("carry wrong");
   a_dest_select: assert property (doShift |=>
      (fileWe_r == $past(destSel)) && (accWe_r != fileWe_r))
      else $error("destination wrong");
   a_zero_flag: assert property (zeroWe_r |->
      zeroFlag_r == (resultOut_r == '0))
      else $error("zero flag wrong");
   a_shift_no_stack: assert property (doShift |=>
      !stackPop_r && !pcLoad_r && !busy_r)
      else $error("shift held the core");
   a_result_hold: assert property (!(accWe_r || fileWe_r) |->
      $stable(resultOut_r))
      else $error("result moved without a shift");

   // Return sequencing: pop, then load, with the core held between
   a_ret_two_cycle: assert property (doRet |=>
      stackPop_r && !pcLoad_r ##1 pcLoad_r && !stackPop_r)
      else $error("return timing wrong");
   a_ret_busy: assert property (doRet |=> busy_r ##1 !busy_r)
      else $error("busy window wrong");
   a_busy_refuse: assert property ((opValid && !idle) |=>
      !accWe_r && !fileWe_r && !stackPop_r)
      else $error("op taken while busy");
   a_pop_single: assert property (stackPop_r |=> !stackPop_r)
      else $error("pop longer than one cycle");
   a_ret_pc_value: assert property (doRet |-> ##2
      pcOut_r == $past(topOfStackEntry, 2))
      else $error("pc not loaded");
   a_pc_hold: assert property (!stackPop_r |-> $stable(pcOut_r))
      else $error("pc moved without a pop");
   a_ret_flags_keep: assert property (doRet |=>
      !carryWe_r && !zeroWe_r)
      else $error("flags written on return");

   // Global enable: raised by interrupt return only, never dropped here
   a_reti_enable: assert property ((doRet && isReti) |-> ##2
      interruptControlReg_r[srr_pkg::GLOBAL_EN_BIT])
      else $error("enable not set");
   a_rets_keep_enable: assert property ((doRet && isRets) |=>
      $stable(interruptControlReg_r) ##1 $stable(interruptControlReg_r))
      else $error("enable changed");
   a_enable_sticky: assert property (
      interruptControlReg_r[srr_pkg::GLOBAL_EN_BIT] |=>
      interruptControlReg_r[srr_pkg::GLOBAL_EN_BIT])
      else $error("enable dropped");

   // Main scenarios: both destinations, both returns, a refused op
   c_shift_acc: cover property (doShift && !toFile);
   c_shift_file: cover property (doShift && toFile);
   c_reti: cover property (doRet && isReti ##2 pcLoad_r);
   c_rets: cover property (doRet && isRets);
   c_busy_refused: cover property (opValid && busy_r);
endmodule : srr_core

// ### tb_shift_right_and_return_ops.sv
module tb_shift_right_and_return_ops;
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus and observed ports
   logic clk_sys, sys_rst, opValid, destSel, g, c, z;
   srr_pkg::srr_op_t opCode;
   logic [7:0] operandIn, resultOut_r, interruptControlReg_r, v;
   logic [14:0] topOfStackEntry, pcOut_r, retAddr;
   logic accWe_r, fileWe_r, carryWe_r, carryFlag_r, zeroWe_r, zeroFlag_r;
   logic stackPop_r, pcLoad_r, busy_r;
   logic [31:0] rnd = 32'h3070;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   wire logic [16:0] shGot = {accWe_r, fileWe_r, resultOut_r, carryWe_r,
      carryFlag_r, zeroWe_r, zeroFlag_r, stackPop_r, pcLoad_r, busy_r};
   wire logic [23:0] rtGot = {stackPop_r, busy_r, pcLoad_r, accWe_r,
      fileWe_r, carryWe_r, zeroWe_r, carryFlag_r, zeroFlag_r, pcOut_r};

   srr_core dut (.clk_sys, .sys_rst, .opValid, .opCode, .destSel,
      .operandIn, .topOfStackEntry, .accWe_r, .fileWe_r, .resultOut_r,
      .carryWe_r, .carryFlag_r, .zeroWe_r, .zeroFlag_r, .stackPop_r,
      .pcLoad_r, .pcOut_r, .interruptControlReg_r, .busy_r);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   // Shift outputs one cycle after the op is taken; top bit always zero
   function automatic logic [16:0] expShift(input logic [7:0] o,
      input logic d);
      return {~d, d, 1'b0, o[7:1], 1'b1, o[0], 1'b1, o[7:1] == 7'h00,
         3'b000};
   endfunction : expShift

   task automatic chk(input logic [23:0] got, exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %s", $time, m);
         n_errors++;
      end
   endtask : chk

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   // Back-to-back shifts, corner operands first, then random
   task automatic shifts(input int n);
      for (int i = 0; i < n; i++)
      begin
         rnd = xs(rnd);
         v = i == 0 ? 8'h00 : i == 1 ? 8'h01 : i == 2 ? 8'h80 :
            i == 3 ? 8'hFF : rnd[7:0];
         opValid = 1'b1;
         opCode = srr_pkg::SRR_OP_SHIFT;
         operandIn = v;
         destSel = rnd[8];
         @(negedge clk_sys);
         chk(shGot, expShift(v, rnd[8]), "shift");
         chk(interruptControlReg_r, {g, 7'h00}, "enable moved");
         c = v[0];
         z = v[7:1] == 7'h00;
      end
      opValid = 1'b0;
      // One idle edge, so the next task never re-raises valid at once
      @(negedge clk_sys);
   endtask : shifts

   // A shift offered while busy must be ignored, so flags must not move
   task automatic ret(input srr_pkg::srr_op_t op);
      rnd = xs(rnd);
      retAddr = rnd[14:0];
      opValid = 1'b1;
      opCode = op;
      topOfStackEntry = retAddr;
      operandIn = 8'h00;
      @(negedge clk_sys);
      chk(rtGot, {7'h60, c, z, retAddr}, "pop");
      opCode = srr_pkg::SRR_OP_SHIFT;
      topOfStackEntry = ~retAddr;
      @(negedge clk_sys);
      opValid = 1'b0;
      if (op == srr_pkg::SRR_OP_RETI)
         g = 1'b1;
      chk(rtGot, {7'h10, c, z, retAddr}, "load");
      chk(interruptControlReg_r, {g, 7'h00}, "enable");
      @(negedge clk_sys);
      chk(rtGot, {7'h00, c, z, retAddr}, "idle");
   endtask : ret

   // ---------------------------------------------------------------
   // Clock, timeout and main sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Whole run needs well under 200 cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 500)
      begin
         n_errors++;
         print_verdict;
      end
   end

   initial
   begin
      {sys_rst, g, c, z} = 4'h8;
      {opValid, destSel, operandIn, topOfStackEntry} = 25'h0000000;
      opCode = srr_pkg::SRR_OP_NONE;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      chk(rtGot, 24'h000000, "reset");
      shifts(12);
      $display("test shifts done");
      ret(srr_pkg::SRR_OP_RETS);
      ret(srr_pkg::SRR_OP_RETI);
      ret(srr_pkg::SRR_OP_RETS);
      $display("test returns done");
      shifts(6);
      sys_rst = 1'b1;
      @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      chk(interruptControlReg_r, 8'h00, "second reset");
      chk(rtGot, 24'h000000, "second reset pc");
      chk(shGot, 17'h00000, "second reset shift");
      $display("test second reset done");
      print_verdict;
   end
endmodule : tb_shift_right_and_return_ops
